// ===== rtl/spmbc_pkg.sv
// Purpose: constants for the serial port mode and baud control block
// Assumes: clk_sys is the oscillator; 12 clocks make one machine cycle
// Notes: register addresses are local choices, see hand-over
package spmbc_pkg;
  // special function register addresses
  localparam logic [7:0] ADDR_SPCTL = 8'h98;
  localparam logic [7:0] ADDR_SERIAL_BUFFER = 8'h99;
  localparam logic [7:0] ADDR_PWR = 8'h87;
  localparam logic [7:0] ADDR_T2CTL = 8'hC8;
  localparam logic [7:0] ADDR_T2RLL = 8'hCA;
  localparam logic [7:0] ADDR_T2RLH = 8'hCB;
  localparam logic [7:0] ADDR_T2CNL = 8'hCC;
  localparam logic [7:0] ADDR_T2CNH = 8'hCD;
  // serial_port_control fields
  localparam int SC_MODE_LO = 7;
  localparam int SC_MODE_HI = 6;
  localparam int SC_MP_EN = 5;
  localparam int SC_RX_EN = 4;
  localparam int SC_TX9 = 3;
  localparam int SC_RX9 = 2;
  localparam int SC_TI = 1;
  localparam int SC_RI = 0;
  localparam int PWR_DOUBLE = 7;
  // timer2_control_reg fields
  localparam int T2_OVF = 7;
  localparam int T2_EXF = 6;
  localparam int T2_RCLK = 5;
  localparam int T2_TX_CLOCK_FROM_T2 = 4;
  localparam int T2_EXEN = 3;
  localparam int T2_RUN = 2;
  localparam int T2_CSEL = 1;
  localparam int T2_CPRL = 0;
  localparam logic [7:0] RST_BYTE = 8'h00;
  // machine cycle phases, S1P1 = 0 ... S6P2 = 11
  localparam logic [3:0] PH_S1P1 = 4'h0;
  localparam logic [3:0] PH_S3P1 = 4'h4;
  localparam logic [3:0] PH_S5P2 = 4'h9;
  localparam logic [3:0] PH_S6P1 = 4'hA;
  localparam logic [3:0] PH_S6P2 = 4'hB;
  // 16 ticks per bit, votes at states 7, 8, 9 (zero based 6..8)
  localparam logic [3:0] DIV16_LAST = 4'hF;
  localparam logic [3:0] VOTE_A = 4'h6;
  localparam logic [3:0] VOTE_B = 4'h7;
  localparam logic [3:0] VOTE_C = 4'h8;
  localparam logic [3:0] M1_BITS = 4'hA;
  localparam logic [3:0] M23_BITS = 4'hB;
  localparam logic [7:0] M0_RX_INIT = 8'hFE;
  localparam logic [1:0] MODE_SHIFT = 2'h0;
  localparam logic [1:0] MODE_UART8 = 2'h1;
  localparam logic [1:0] MODE_FIXED = 2'h2;
  localparam logic [15:0] T2_TOP = 16'hFFFF;
endpackage

// ===== rtl/spmbc_fifo.sv
// Purpose: transmit-side word FIFO with valid/ready on both sides
// Assumes: same clock on both sides
// Notes: in_ready and out_valid come from flip-flops
`timescale 1ns/10ps
module spmbc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic clk_sys, // clock
  input wire logic rst, // synchronous reset
  input wire logic in_valid, // write request
  output logic in_ready, // room for a word
  input wire logic [WIDTH-1:0] in_data, // word written
  output logic out_valid, // word available
  input wire logic out_ready, // consumer takes word
  output logic [WIDTH-1:0] out_data // head word
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic [AW:0] next_count;
  logic push;
  logic pop;

  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_data = mem[rd_ptr];

  always_comb begin
    next_count = count;
    if (push & ~pop) begin
      next_count = count + 1'b1;
    end else if (pop & ~push) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      in_ready <= 1'b1;
      out_valid <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= next_count;
      in_ready <= next_count < (AW + 1)'(DEPTH);
      out_valid <= next_count != '0;
    end
  end
endmodule

// ===== rtl/spmbc_top.sv
// Purpose: serial port with four modes, baud selection and timer 2
// Assumes: CPU reaches registers through the special function port
// Notes: serial_buffer writes queue in a FIFO ahead of the shifter
`timescale 1ns/10ps
module spmbc_top
  import spmbc_pkg::*;
#(
  parameter int FIFO_DEPTH = 32
) (
  input wire logic clk_sys, // oscillator, 250 MHz
  input wire logic rst, // synchronous, active high
  input wire logic [7:0] sfr_addr, // register address
  input wire logic sfr_wr, // write strobe, one cycle
  input wire logic sfr_rd, // read strobe, one cycle
  input wire logic [7:0] sfr_wdata, // write data
  output logic [7:0] sfr_rdata, // read data, next cycle
  output logic tx_buf_ready, // transmit FIFO can take a write
  input wire logic timer1_overflow, // timer 1 overflow pulse
  input wire logic rxd_in, // data pin level
  output logic rxd_out, // data pin drive value
  output logic rxd_oe_n, // data pin enable, low drives
  output logic txd_out, // transmit pin or shift clock
  input wire logic timer2_external_pin, // timer 2 external pin
  input wire logic timer2_count_pin // timer 2 count input
);
  typedef enum logic [2:0] {
    T_IDLE, T_WAIT0, T_SEND0, T_AWAIT, T_ASYNC
  } spmbc_tx_t;
  typedef enum logic [2:0] {
    R_IDLE, R_ARM0, R_SHIFT0, R_DONE0, R_ASYNC
  } spmbc_rx_t;

  spmbc_tx_t tx_state;
  spmbc_rx_t rx_state;
  logic [1:0] mode;
  logic mp_en, rx_en, tx9, rx9, ti, ri, rate_double;
  logic t2_ovf_flag, t2_ext_flag, rclk, tx_clock_from_t2, t2_exen, t2_run;
  logic t2_csel, t2_cprl;
  logic [15:0] t2_reload, t2_count;
  logic [7:0] rx_buffer;
  logic [1:0] rxd_sync, ext_sync, cnt_sync;
  logic rxd_prev, ext_prev, cnt_prev;
  logic [3:0] phase;
  logic [1:0] pre_cnt;
  logic t1_half;
  logic [3:0] tx_div, rx_div, tx_bits, rx_bit;
  logic [10:0] tx_sh;
  logic tx_gap;
  logic [7:0] rx_sh;
  logic [1:0] votes;
  logic rx_ninth, m0_samp;
  logic wr_serial_port_control, wr_serial_buffer, fifo_valid, tx_pop;
  logic [7:0] fifo_data;
  logic state_tick, m2_tick, t1_tick, t2_inc, t2_ovf;
  logic tx_tick, rx_tick, tx_roll, rx_decide, rx_maj;
  logic ti_set, ri_set, rx_accept, rx_flag, m0_active;
  logic [3:0] rx_last;
  logic next_txd, next_rxd_out, next_oe_n;
  logic [7:0] next_rdata;

  assign wr_serial_port_control = sfr_wr & (sfr_addr == ADDR_SPCTL);
  assign wr_serial_buffer = sfr_wr & (sfr_addr == ADDR_SERIAL_BUFFER);

  // pins pass two flip-flops before any use
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rxd_sync <= 2'h3;
      ext_sync <= 2'h3;
      cnt_sync <= 2'h3;
      rxd_prev <= 1'b1;
      ext_prev <= 1'b1;
      cnt_prev <= 1'b1;
    end else begin
      rxd_sync <= {rxd_sync[0], rxd_in};
      ext_sync <= {ext_sync[0], timer2_external_pin};
      cnt_sync <= {cnt_sync[0], timer2_count_pin};
      rxd_prev <= rxd_sync[1];
      ext_prev <= ext_sync[1];
      cnt_prev <= cnt_sync[1];
    end
  end

  // machine cycle phase and rate prescalers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      phase <= PH_S1P1;
      pre_cnt <= 2'h0;
      t1_half <= 1'b0;
    end else begin
      phase <= (phase == PH_S6P2) ? PH_S1P1 : phase + 4'h1;
      pre_cnt <= pre_cnt + 2'h1;
      if (timer1_overflow) begin
        t1_half <= ~t1_half;
      end
    end
  end

  assign state_tick = phase[0];
  // 16 ticks per bit: osc/4 or osc/2 gives osc/64 or osc/32
  assign m2_tick = rate_double ? pre_cnt[0] : (pre_cnt == 2'h3);
  assign t1_tick = timer1_overflow & (rate_double | t1_half);
  assign tx_tick = (mode == MODE_FIXED) ? m2_tick :
                   (tx_clock_from_t2 ? t2_ovf : t1_tick);
  assign rx_tick = (mode == MODE_FIXED) ? m2_tick :
                   (rclk ? t2_ovf : t1_tick);

  // timer 2 as baud generator
  assign t2_inc = t2_run & (rclk | tx_clock_from_t2) &
                  (t2_csel ? (cnt_prev & ~cnt_sync[1]) : state_tick);
  assign t2_ovf = t2_inc & (t2_count == T2_TOP);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      t2_count <= {RST_BYTE, RST_BYTE};
    end else if (sfr_wr & (sfr_addr == ADDR_T2CNL)) begin
      t2_count[7:0] <= sfr_wdata;
    end else if (sfr_wr & (sfr_addr == ADDR_T2CNH)) begin
      t2_count[15:8] <= sfr_wdata;
    end else if (t2_ovf) begin
      t2_count <= t2_reload;
    end else if (t2_inc) begin
      t2_count <= t2_count + 16'h1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      t2_reload <= {RST_BYTE, RST_BYTE};
    end else if (sfr_wr & (sfr_addr == ADDR_T2RLL)) begin
      t2_reload[7:0] <= sfr_wdata;
    end else if (sfr_wr & (sfr_addr == ADDR_T2RLH)) begin
      t2_reload[15:8] <= sfr_wdata;
    end
  end

  // timer 2 control; the baud rollover never touches the overflow flag
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      {t2_ovf_flag, rclk, tx_clock_from_t2, t2_exen, t2_run, t2_csel, t2_cprl} <= '0;
      t2_ext_flag <= 1'b0;
      rate_double <= 1'b0;
    end else begin
      if (sfr_wr & (sfr_addr == ADDR_T2CTL)) begin
        t2_ovf_flag <= sfr_wdata[T2_OVF];
        rclk <= sfr_wdata[T2_RCLK];
        tx_clock_from_t2 <= sfr_wdata[T2_TX_CLOCK_FROM_T2];
        t2_exen <= sfr_wdata[T2_EXEN];
        t2_run <= sfr_wdata[T2_RUN];
        t2_csel <= sfr_wdata[T2_CSEL];
        t2_cprl <= sfr_wdata[T2_CPRL];
      end
      if (t2_exen & ext_prev & ~ext_sync[1]) begin
        t2_ext_flag <= 1'b1;
      end else if (sfr_wr & (sfr_addr == ADDR_T2CTL)) begin
        t2_ext_flag <= sfr_wdata[T2_EXF];
      end
      if (sfr_wr & (sfr_addr == ADDR_PWR)) begin
        rate_double <= sfr_wdata[PWR_DOUBLE];
      end
    end
  end

  // serial port control; hardware set wins over a software clear
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      {mode, mp_en, rx_en, tx9} <= '0;
      ti <= 1'b0;
      ri <= 1'b0;
      rx9 <= 1'b0;
    end else begin
      if (wr_serial_port_control) begin
        mode <= {sfr_wdata[SC_MODE_LO], sfr_wdata[SC_MODE_HI]};
        mp_en <= sfr_wdata[SC_MP_EN];
        rx_en <= sfr_wdata[SC_RX_EN];
        tx9 <= sfr_wdata[SC_TX9];
      end
      if (ti_set) begin
        ti <= 1'b1;
      end else if (wr_serial_port_control) begin
        ti <= sfr_wdata[SC_TI];
      end
      if (ri_set) begin
        ri <= 1'b1;
      end else if (wr_serial_port_control) begin
        ri <= sfr_wdata[SC_RI];
      end
      if (rx_state == R_ASYNC && rx_decide && rx_bit == rx_last &&
          rx_accept) begin
        rx9 <= rx_flag;
      end else if (wr_serial_port_control) begin
        rx9 <= sfr_wdata[SC_RX9];
      end
    end
  end

  spmbc_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_tx_fifo (
    .clk_sys(clk_sys),
    .rst(rst),
    .in_valid(wr_serial_buffer),
    .in_ready(tx_buf_ready),
    .in_data(sfr_wdata),
    .out_valid(fifo_valid),
    .out_ready(tx_pop),
    .out_data(fifo_data)
  );

  // transmitter
  assign tx_pop = (tx_state == T_IDLE) & fifo_valid;
  assign tx_roll = tx_tick & (tx_div == DIV16_LAST);
  assign ti_set = ((tx_state == T_SEND0) & (phase == PH_S1P1) &
                   (tx_sh[10:1] == 10'h0)) |
                  ((tx_state == T_ASYNC) & tx_roll & (tx_bits == 4'h2));

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tx_div <= 4'h0;
    end else if (tx_tick) begin
      tx_div <= tx_div + 4'h1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tx_state <= T_IDLE;
      tx_sh <= 11'h7FF;
      tx_bits <= 4'h0;
      tx_gap <= 1'b0;
    end else begin
      case (tx_state)
        T_IDLE: begin
          tx_gap <= 1'b0;
          if (tx_pop && mode == MODE_SHIFT) begin
            tx_sh <= {3'h1, fifo_data};
            tx_state <= T_WAIT0;
          end else if (tx_pop) begin
            // stop, ninth or second stop, data, start
            tx_sh <= {1'b1, (mode == MODE_UART8) | tx9,
                      fifo_data, 1'b0};
            tx_bits <= (mode == MODE_UART8) ? M1_BITS : M23_BITS;
            tx_state <= T_AWAIT;
          end
        end
        T_WAIT0: begin
          // first S6P2 marks the write, the second ends the gap cycle
          if (phase == PH_S6P2) begin
            tx_gap <= 1'b1;
            if (tx_gap) begin
              tx_state <= T_SEND0;
            end
          end
        end
        T_SEND0: begin
          if (phase == PH_S6P2) begin
            tx_sh <= {1'b0, tx_sh[10:1]};
          end else if (phase == PH_S1P1 && tx_sh[10:1] == 10'h0) begin
            tx_state <= T_IDLE;
            tx_sh <= 11'h7FF;
          end
        end
        T_AWAIT: begin
          if (tx_roll) begin
            tx_state <= T_ASYNC;
          end
        end
        T_ASYNC: begin
          if (tx_roll) begin
            if (tx_bits == 4'h1) begin
              tx_state <= T_IDLE;
            end else begin
              tx_sh <= {1'b1, tx_sh[10:1]};
              tx_bits <= tx_bits - 4'h1;
            end
          end
        end
        default: begin
          tx_state <= T_IDLE;
        end
      endcase
    end
  end

  // receiver
  assign rx_decide = rx_tick & (rx_div == VOTE_C);
  assign rx_maj = (votes[0] & votes[1]) |
                  (rxd_sync[1] & (votes[0] | votes[1]));
  assign rx_last = (mode == MODE_UART8) ? 4'h9 : 4'hA;
  assign rx_flag = (mode == MODE_UART8) ? rx_maj : rx_ninth;
  assign rx_accept = ~ri & (~mp_en | rx_flag);
  assign ri_set = ((rx_state == R_DONE0) & (phase == PH_S1P1)) |
                  ((rx_state == R_ASYNC) & rx_decide &
                   (rx_bit == rx_last) & rx_accept);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rx_state <= R_IDLE;
      rx_div <= 4'h0;
      rx_bit <= 4'h0;
      rx_sh <= 8'hFF;
      votes <= 2'h0;
      rx_ninth <= 1'b0;
      m0_samp <= 1'b1;
      rx_buffer <= RST_BYTE;
    end else if (!rx_en && rx_state != R_DONE0) begin
      rx_state <= R_IDLE;
    end else begin
      case (rx_state)
        R_IDLE: begin
          if (mode == MODE_SHIFT) begin
            if (!ri) begin
              rx_state <= R_ARM0;
            end
          end else if (rxd_prev && !rxd_sync[1]) begin
            rx_div <= 4'h0;
            rx_bit <= 4'h0;
            rx_state <= R_ASYNC;
          end
        end
        R_ARM0: begin
          if (phase == PH_S6P2) begin
            rx_sh <= M0_RX_INIT;
            rx_state <= R_SHIFT0;
          end
        end
        R_SHIFT0: begin
          if (phase == PH_S5P2) begin
            m0_samp <= rxd_sync[1];
          end else if (phase == PH_S6P1) begin
            rx_sh <= {rx_sh[6:0], m0_samp};
            if (!rx_sh[7]) begin
              rx_buffer <= {<<{rx_sh[6:0], m0_samp}};
              rx_state <= R_DONE0;
            end
          end
        end
        R_DONE0: begin
          if (phase == PH_S1P1) begin
            rx_state <= R_IDLE;
          end
        end
        R_ASYNC: begin
          if (rx_tick) begin
            rx_div <= rx_div + 4'h1;
            if (rx_div == VOTE_A) begin
              votes[0] <= rxd_sync[1];
            end
            if (rx_div == VOTE_B) begin
              votes[1] <= rxd_sync[1];
            end
            if (rx_div == DIV16_LAST) begin
              rx_bit <= rx_bit + 4'h1;
            end
          end
          if (rx_decide) begin
            if (rx_bit == 4'h0 && rx_maj) begin
              rx_state <= R_IDLE;
            end else if (rx_bit >= 4'h1 && rx_bit <= 4'h8) begin
              rx_sh <= {rx_maj, rx_sh[7:1]};
            end else if (rx_bit == rx_last) begin
              if (rx_accept) begin
                rx_buffer <= rx_sh;
              end
              rx_state <= R_IDLE;
            end else if (rx_bit == 4'h9) begin
              rx_ninth <= rx_maj;
            end
          end
        end
        default: begin
          rx_state <= R_IDLE;
        end
      endcase
    end
  end

  // pin outputs, shift clock low in S3 to S5
  assign m0_active = (tx_state == T_SEND0) | (rx_state == R_SHIFT0);
  always_comb begin
    next_txd = 1'b1;
    next_rxd_out = 1'b1;
    next_oe_n = 1'b1;
    if (m0_active) begin
      next_txd = ~((phase >= PH_S3P1) && (phase <= PH_S5P2));
    end else if (tx_state == T_ASYNC) begin
      next_txd = tx_sh[0];
    end
    if (tx_state == T_SEND0) begin
      next_rxd_out = tx_sh[0];
      next_oe_n = 1'b0;
    end
  end

  always_comb begin
    next_rdata = 8'h00;
    case (sfr_addr)
      ADDR_SPCTL: next_rdata = {mode, mp_en, rx_en, tx9, rx9, ti, ri};
      ADDR_SERIAL_BUFFER: next_rdata = rx_buffer;
      ADDR_PWR: next_rdata = {rate_double, 7'h00};
      ADDR_T2CTL: next_rdata = {t2_ovf_flag, t2_ext_flag, rclk, tx_clock_from_t2,
                                t2_exen, t2_run, t2_csel, t2_cprl};
      ADDR_T2RLL: next_rdata = t2_reload[7:0];
      ADDR_T2RLH: next_rdata = t2_reload[15:8];
      ADDR_T2CNL: next_rdata = t2_count[7:0];
      ADDR_T2CNH: next_rdata = t2_count[15:8];
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      txd_out <= 1'b1;
      rxd_out <= 1'b1;
      rxd_oe_n <= 1'b1;
      sfr_rdata <= 8'h00;
    end else begin
      txd_out <= next_txd;
      rxd_out <= next_rxd_out;
      rxd_oe_n <= next_oe_n;
      if (sfr_rd) begin
        sfr_rdata <= next_rdata;
      end
    end
  end
endmodule

// ===== test/spmbc_top_assertions.sv
// Purpose: port checks for spmbc_top
// Assumes: control and power writes are shadowed here
// Notes: mode 2 bit length follows the shadowed double bit
`timescale 1ns/10ps
module spmbc_chk
  import spmbc_pkg::*;
#(
  parameter int FIFO_DEPTH = 32
) (
  input wire logic clk_sys, // clock
  input wire logic rst, // reset
  input wire logic [7:0] sfr_addr, // address
  input wire logic sfr_wr, // write
  input wire logic sfr_rd, // read
  input wire logic [7:0] sfr_wdata, // write data
  input wire logic [7:0] sfr_rdata, // read data
  input wire logic tx_buf_ready, // fifo room
  input wire logic timer1_overflow, // t1 tick
  input wire logic rxd_in, // pin in
  input wire logic rxd_out, // pin out
  input wire logic rxd_oe_n, // pin enable
  input wire logic txd_out, // line or clock
  input wire logic timer2_external_pin, // t2 ext
  input wire logic timer2_count_pin // t2 count
);
  logic [7:0] ctl;
  logic dbl;
  logic [9:0] low_run;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  always_ff @(posedge clk_sys) begin
    if (rst) ctl <= 8'h00;
    else if (sfr_wr && sfr_addr == ADDR_SPCTL) ctl <= sfr_wdata;
  end
  always_ff @(posedge clk_sys) begin
    if (rst) dbl <= 1'b0;
    else if (sfr_wr && sfr_addr == ADDR_PWR) dbl <= sfr_wdata[7];
  end
  // length of the current low stretch on the line
  always_ff @(posedge clk_sys) begin
    if (rst || txd_out) low_run <= 10'h000;
    else if (low_run != 10'h3FF) low_run <= low_run + 10'h001;
  end
  reset_idle_a: assert property (
    disable iff (1'b0) rst |=> txd_out && rxd_oe_n && sfr_rdata == 8'h00)
    else $error("outputs not idle after reset");
  shift_only_a: assert property (
    !rxd_oe_n |-> ctl[7:6] == MODE_SHIFT)
    else $error("data pin driven outside shift mode");
  clk_low_a: assert property (
    $fell(txd_out) && ctl[7:6] == MODE_SHIFT |=> !txd_out [*5] ##1 txd_out)
    else $error("shift clock low time wrong");
  send_clock_a: assert property (
    $fell(rxd_oe_n) |-> ##[1:12] $fell(txd_out))
    else $error("no shift clock after send start");
  data_edge_a: assert property (
    !rxd_oe_n && !$past(rxd_oe_n) && $changed(rxd_out) |-> txd_out)
    else $error("data moved while shift clock low");
  m2_bit_len_a: assert property (
    ctl[7:6] == MODE_FIXED && $rose(txd_out) |-> low_run != 10'h000
    && (dbl ? low_run[4:0] == 5'h00 : low_run[5:0] == 6'h00))
    else $error("mode 2 bit time wrong");
  ctl_back_a: assert property (
    sfr_rd && sfr_addr == ADDR_SPCTL |=> sfr_rdata[7:3] == $past(ctl[7:3]))
    else $error("control bits read back wrong");
  pwr_back_a: assert property (
    sfr_rd && sfr_addr == ADDR_PWR |=> sfr_rdata[7] == $past(dbl))
    else $error("double bit read back wrong");
  unmapped_a: assert property (
    sfr_rd && sfr_addr == 8'h00 |=> sfr_rdata == 8'h00)
    else $error("unmapped read not zero");
endmodule
bind spmbc_top spmbc_chk #(.FIFO_DEPTH(FIFO_DEPTH)) u_chk (
  .clk_sys(clk_sys),
  .rst(rst),
  .sfr_addr(sfr_addr),
  .sfr_wr(sfr_wr),
  .sfr_rd(sfr_rd),
  .sfr_wdata(sfr_wdata),
  .sfr_rdata(sfr_rdata),
  .tx_buf_ready(tx_buf_ready),
  .timer1_overflow(timer1_overflow),
  .rxd_in(rxd_in),
  .rxd_out(rxd_out),
  .rxd_oe_n(rxd_oe_n),
  .txd_out(txd_out),
  .timer2_external_pin(timer2_external_pin),
  .timer2_count_pin(timer2_count_pin)
);

// ===== test/spmbc_peer.sv
// Purpose: far-side serial peer and shift device
// Assumes: line idles high as with a pull-up
// Notes: shift device moves on each falling shift clock
`timescale 1ns/10ps
module spmbc_peer (
  input wire logic clk_sys, // clock
  input wire logic txd_out, // line or shift clock
  output logic line // level driven to the pin
);
  logic [7:0] m0_byte = 8'h00;
  logic m0_on = 1'b0;
  initial line = 1'b1;
  // next bit ready before the S5P2 sample
  always @(negedge txd_out) begin
    if (m0_on) begin
      line <= m0_byte[0];
      m0_byte <= {~m0_byte[0], m0_byte[7:1]};
    end
  end
  task automatic m0(input logic on, input logic [7:0] b);
    m0_on = on;
    m0_byte = b;
    line <= 1'b1;
  endtask
  task automatic send(input logic [10:0] bits, input int n, input int clks);
    for (int i = 0; i < n; i++) begin
      line <= bits[i];
      repeat (clks) @(posedge clk_sys);
    end
    line <= 1'b1;
  endtask
endmodule

// ===== test/spmbc_top_test.sv
// Purpose: self-checking bench for spmbc_top
// Assumes: peer drives the data pin whenever the device does not
// Notes: mode 2 runs doubled, 32 clocks a bit
`timescale 1ns/10ps
module spmbc_top_test
  import spmbc_pkg::*;
;
  typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] e;} spmbc_row_t;
  typedef struct packed {
    logic [7:0] c; logic [7:0] d; logic n9; logic [7:0] ec; logic [7:0] eb;
  } spmbc_rx_t;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic [7:0] sfr_wdata = 8'h00;
  logic [7:0] sfr_rdata, rd_val, got;
  logic tx_buf_ready, rxd_out, rxd_oe_n, txd_out, peer_line, last;
  logic [10:0] frame;
  int err_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  int n;
  wire rxd_pin = rxd_oe_n ? peer_line : rxd_out;
  spmbc_row_t rows [10] = '{
    '{ADDR_SPCTL, 8'hE8, 8'hE8}, '{ADDR_PWR, 8'h80, 8'h80},
    '{ADDR_T2CTL, 8'h03, 8'h03}, '{ADDR_T2RLL, 8'h5A, 8'h5A},
    '{ADDR_T2RLH, 8'hA5, 8'hA5}, '{ADDR_T2CNL, 8'h3C, 8'h3C},
    '{ADDR_T2CNH, 8'hC3, 8'hC3}, '{8'h00, 8'hFF, 8'h00},
    '{ADDR_SPCTL, 8'h00, 8'h00}, '{ADDR_PWR, 8'h80, 8'h80}};
  spmbc_rx_t rxr [6] = '{
    '{8'hB0, 8'h5A, 1'b0, 8'hB0, 8'h35}, '{8'hB0, 8'h96, 1'b1, 8'hB5, 8'h96},
    '{8'h90, 8'h69, 1'b0, 8'h91, 8'h69}, '{8'h80, 8'hF0, 1'b1, 8'h80, 8'h69},
    '{8'h50, 8'hC6, 1'b1, 8'h55, 8'hC6}, '{8'h70, 8'h3A, 1'b0, 8'h70, 8'hC6}};
  spmbc_top u_dut (
    .clk_sys(clk_sys),
    .rst(rst),
    .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata),
    .tx_buf_ready(tx_buf_ready),
    .timer1_overflow(1'b0),
    .rxd_in(rxd_pin),
    .rxd_out(rxd_out),
    .rxd_oe_n(rxd_oe_n),
    .txd_out(txd_out),
    .timer2_external_pin(1'b1),
    .timer2_count_pin(1'b1)
  );
  spmbc_peer u_peer (.clk_sys(clk_sys), .txd_out(txd_out), .line(peer_line));
  initial begin
    forever #2 clk_sys = ~clk_sys;
  end
  task automatic chk(input string name, input logic [7:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic results();
    if (err_count == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, d);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge clk_sys);
    sfr_wr <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [7:0] a);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge clk_sys);
    sfr_rd <= 1'b0;
    @(posedge clk_sys);
    rd_val = sfr_rdata;
  endtask
  task automatic poll(input int bit_no);
    repeat (100) begin
      rd(ADDR_SPCTL);
      if (rd_val[bit_no] === 1'b1) break;
    end
  endtask
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      results();
    end
  end
  initial begin
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    chk("idle pins", {4'h0, txd_out, rxd_oe_n, tx_buf_ready, rxd_out}, 8'h0F);
    foreach (rows[i]) begin
      rd(rows[i].a);
      chk("reset value", rd_val, 8'h00);
    end
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a);
      chk("register", rd_val, rows[i].e);
    end
    // shift mode send, bits taken at each rising shift clock
    wr(ADDR_SERIAL_BUFFER, 8'hA5);
    got = 8'h00;
    n = 0;
    last = 1'b1;
    for (int i = 0; i < 400 && n < 8; i++) begin
      @(posedge clk_sys);
      if (!rxd_oe_n && txd_out && !last) begin
        got = {rxd_out, got[7:1]};
        n++;
      end
      last = txd_out;
    end
    chk("m0 send data", got, 8'hA5);
    poll(SC_TI);
    chk("m0 send flag", rd_val, 8'h02);
    wr(ADDR_SPCTL, 8'h00);
    rd(ADDR_SPCTL);
    chk("flag cleared", rd_val, 8'h00);
    u_peer.m0(1'b1, 8'h35);
    wr(ADDR_SPCTL, 8'h10);
    poll(SC_RI);
    chk("m0 rx flag", rd_val, 8'h11);
    rd(ADDR_SERIAL_BUFFER);
    chk("m0 rx data", rd_val, 8'h35);
    wr(ADDR_SPCTL, 8'h00);
    u_peer.m0(1'b0, 8'h00);
    // timer 2 stopped while loaded, then run as a 32-clock bit source
    wr(ADDR_T2CNL, 8'hFF);
    wr(ADDR_T2CNH, 8'hFF);
    wr(ADDR_T2RLL, 8'hFF);
    wr(ADDR_T2RLH, 8'hFF);
    wr(ADDR_T2CTL, 8'h34);
    foreach (rxr[i]) begin
      wr(ADDR_SPCTL, rxr[i].c);
      u_peer.send({1'b1, rxr[i].n9, rxr[i].d, 1'b0}, 11, 32);
      repeat (8) @(posedge clk_sys);
      rd(ADDR_SPCTL);
      chk("rx flags", rd_val, rxr[i].ec);
      rd(ADDR_SERIAL_BUFFER);
      chk("rx data", rd_val, rxr[i].eb);
    end
    wr(ADDR_SPCTL, 8'h88);
    wr(ADDR_SERIAL_BUFFER, 8'hC3);
    for (int i = 0; i < 200 && txd_out; i++) @(posedge clk_sys);
    repeat (16) @(posedge clk_sys);
    for (int i = 0; i < 11; i++) begin
      frame = {txd_out, frame[10:1]};
      repeat (32) @(posedge clk_sys);
    end
    chk("m2 tx low", frame[7:0], 8'h86);
    chk("m2 tx high", {5'h00, frame[10:8]}, 8'h07);
    rd(ADDR_SPCTL);
    chk("m2 tx flag", rd_val, 8'h8A);
    wr(ADDR_SPCTL, 8'h80);
    for (int i = 0; i < 34; i++) wr(ADDR_SERIAL_BUFFER, i[7:0]);
    chk("fifo full", {7'h00, tx_buf_ready}, 8'h00);
    for (int i = 0; i < 800 && !tx_buf_ready; i++) @(posedge clk_sys);
    chk("fifo drains", {7'h00, tx_buf_ready}, 8'h01);
    results();
  end
endmodule
